// ### mmp_core_model.sv
/*
  mmp_core_model: core-side master of the register port of mmp_top.
  Assumes: one clock, one-cycle strobes, read data only in the next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module mmp_core_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  // idle bus; all traffic stays inside the core
  initial
  begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // one-cycle write, returns at the edge that takes it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d; // stale data must never look valid
  endtask : wr_reg

  // data stand only in the cycle after the strobe, so grab them there
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
endmodule : mmp_core_model
`default_nettype wire

// ### mmp_pkg.sv
/*
  mmp_pkg: offsets, field positions, reset values and mode codes of the
  memory map position control block.
  Assumes: byte-wide register port, one clock, mode supplied by the core.
*/
package mmp_pkg;

  // register offsets (byte addresses of the core register window)
  localparam logic [7:0] OFF_RAM_POS   = 8'h10;
  localparam logic [7:0] OFF_REG_POS   = 8'h11;
  localparam logic [7:0] OFF_EE_POS    = 8'h12;
  localparam logic [7:0] OFF_SYS_CTL   = 8'h13;
  localparam logic [7:0] OFF_MEM_SIZE0 = 8'h1c;
  localparam logic [7:0] OFF_MEM_SIZE1 = 8'h1d;
  localparam logic [7:0] OFF_PAGE_IDX  = 8'h30;

  // writable bit masks
  localparam logic [7:0] MASK_RAM_POS  = 8'hf9;
  localparam logic [7:0] MASK_REG_POS  = 8'h78;
  localparam logic [7:0] MASK_EE_BASE  = 8'hf8;
  localparam logic [7:0] MASK_EE_EN    = 8'h01;
  localparam logic [7:0] MASK_SYS_CTL  = 8'h0f;
  localparam logic [7:0] MASK_PAGE_IDX = 8'h3f;

  // field positions
  localparam int RAM_ALIGN_BIT  = 0;
  localparam int EE_EN_BIT      = 0;
  localparam int FLASH_EN_BIT   = 0;
  localparam int FLASH_HALF_BIT = 1;
  localparam int STRETCH_LSB    = 2;
  localparam int REG_SIZE_BIT   = 7;
  localparam int RAM_SIZE_LSB   = 0;

  // reset values
  localparam logic [7:0] RST_RAM_POS  = 8'h09;
  localparam logic [7:0] RST_REG_POS  = 8'h00;
  localparam logic [7:0] RST_EE_POS   = 8'h01;
  localparam logic [7:0] RST_SYS_CTL  = 8'h0d;
  localparam logic [7:0] RST_SYS_TEST = 8'h0c;
  localparam logic [7:0] RST_PAGE_IDX = 8'h00;

  // operating modes as encoded by the core mode bits
  localparam logic [2:0] MODE_SPEC_SINGLE = 3'h0;
  localparam logic [2:0] MODE_SPEC_NARROW = 3'h1;
  localparam logic [2:0] MODE_SPEC_PERIPH = 3'h2;
  localparam logic [2:0] MODE_SPEC_TEST   = 3'h3;
  localparam logic [2:0] MODE_NORM_SINGLE = 3'h4;
  localparam logic [2:0] MODE_NORM_NARROW = 3'h5;
  localparam logic [2:0] MODE_NORM_EMUL   = 3'h6;
  localparam logic [2:0] MODE_NORM_WIDE   = 3'h7;

  // selected region, highest priority first
  typedef enum logic [2:0] {
    MMP_SEL_REGS,
    MMP_SEL_RAM,
    MMP_SEL_EE,
    MMP_SEL_FLASH,
    MMP_SEL_EXT
  } mmp_sel_e;

endpackage : mmp_pkg

// ### mmp_top.sv
/*
  mmp_top: memory map position control registers and region decode.
  Assumes: register port and decode address come from the core, the
  mode is stable outside reset, size switches are integration straps.
*/
// Chosen here: the plain strobed port.
// Operation
// - no device pins, core-internal only
// - position and control registers at 0x10..0x13
// - two read-only size registers
// - six-bit page index, upper bits zero
// - ram position write-once unless special mode
// - map changes one cycle after write
// - ram bits supply address 15..11
// - align bit picks bottom or top
// - register position write-once unless special
// - register block 1K/2K, 2K boundary, low 32K
// - register base bit 15 fixed zero
// - eeprom enable writable always
// - eeprom base protection chosen at integration
// - eeprom bits supply address 15..11
// - eeprom enable adds or removes eeprom
// - stretch field 0..3, ignored single/peripheral
// - flash enable bit adds or removes flash
// - ram position resets to 0x09
`timescale 1ns/1ps
`default_nettype none
module mmp_top #(
  parameter bit         EE_BASE_ONCE = 1'b0,
  parameter logic [7:0] SIZE_SECOND  = 8'h00
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic [2:0]  MODE,
  input  wire logic        REG_SIZE_2K,
  input  wire logic [1:0]  EE_SIZE_SEL,
  input  wire logic [2:0]  RAM_SIZE_SEL,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic [15:0] MAP_ADDR,
  output logic      [4:0]  MAP_SEL,
  output logic      [1:0]  STRETCH_COUNT,
  output logic      [15:0] RAM_BASE,
  output logic      [15:0] REG_BASE,
  output logic      [15:0] EE_BASE
);

  logic       special;
  logic       single_or_periph;
  logic       wr_ram;
  logic       wr_reg;
  logic       wr_ee;
  logic       wr_sys;
  logic       wr_page;
  logic [7:0] ram_pos;
  logic [7:0] reg_pos;
  logic [7:0] ee_pos;
  logic [7:0] sys_ctl_r;
  logic       sys_used_r;
  logic [7:0] page_idx_r;
  logic [7:0] size_first;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       ram_used;
  logic       reg_used;
  logic       ee_used;
  logic [7:0] ram_once;
  logic [7:0] ram_any;
  logic [7:0] ee_once;
  logic [7:0] ee_any;
  logic [7:0] reg_once;
  logic [7:0] reg_any;
  logic [7:0] sys_mask;
  logic       rst_seen_r;

  // mode classes; special modes have the top mode bit clear
  assign special          = ~MODE[2];
  assign single_or_periph = (MODE == mmp_pkg::MODE_SPEC_SINGLE) ||
                            (MODE == mmp_pkg::MODE_SPEC_PERIPH) ||
                            (MODE == mmp_pkg::MODE_NORM_SINGLE);

  // write decode, no external pins: everything faces the core
  assign wr_ram  = WR && (ADDR == mmp_pkg::OFF_RAM_POS);
  assign wr_reg  = WR && (ADDR == mmp_pkg::OFF_REG_POS);
  assign wr_ee   = WR && (ADDR == mmp_pkg::OFF_EE_POS);
  assign wr_sys  = WR && (ADDR == mmp_pkg::OFF_SYS_CTL);
  assign wr_page = WR && (ADDR == mmp_pkg::OFF_PAGE_IDX);

  // protection masks: once-only in normal modes, always in special
  assign ram_any  = special ? mmp_pkg::MASK_RAM_POS : 8'h00;
  assign ram_once = mmp_pkg::MASK_RAM_POS;
  assign reg_any  = special ? mmp_pkg::MASK_REG_POS : 8'h00;
  assign reg_once = mmp_pkg::MASK_REG_POS;
  // eeprom enable always writable; base per integration choice
  assign ee_any  = mmp_pkg::MASK_EE_EN |
                   ((special || !EE_BASE_ONCE) ? mmp_pkg::MASK_EE_BASE : 8'h00);
  assign ee_once = mmp_pkg::MASK_EE_BASE;

  // ram position, reset value 0x09; unused bits never stored
  mmp_wreg #(
    .RESET_VAL (mmp_pkg::RST_RAM_POS)
  ) u_ram_pos (
    .clk        (CORE_CLK),
    .rst_n      (RST_N),
    .wr         (wr_ram),
    .wdata      (WDATA),
    .wmask_any  (ram_any),
    .wmask_once (ram_once),
    .once_ok    (1'b1),
    .q          (ram_pos),
    .used       (ram_used)
  );

  mmp_wreg #(
    .RESET_VAL (mmp_pkg::RST_REG_POS)
  ) u_reg_pos (
    .clk        (CORE_CLK),
    .rst_n      (RST_N),
    .wr         (wr_reg),
    .wdata      (WDATA),
    .wmask_any  (reg_any),
    .wmask_once (reg_once),
    .once_ok    (1'b1),
    .q          (reg_pos),
    .used       (reg_used)
  );

  // ee used flag counts only base-carrying writes is not needed: any write closes it
  mmp_wreg #(
    .RESET_VAL (mmp_pkg::RST_EE_POS)
  ) u_ee_pos (
    .clk        (CORE_CLK),
    .rst_n      (RST_N),
    .wr         (wr_ee),
    .wdata      (WDATA),
    .wmask_any  (ee_any),
    .wmask_once (ee_once),
    .once_ok    (EE_BASE_ONCE),
    .q          (ee_pos),
    .used       (ee_used)
  );

  // system control: write-once in normal modes, anytime in special
  assign sys_mask = (special || !sys_used_r) ? mmp_pkg::MASK_SYS_CTL : 8'h00;

  // reset value depends on mode, caught at the first clock after release
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sys_ctl_r  <= mmp_pkg::RST_SYS_CTL;
      sys_used_r <= 1'b0;
      rst_seen_r <= 1'b0;
    end
    else if (!rst_seen_r)
    begin
      rst_seen_r <= 1'b1;
      sys_ctl_r  <= (MODE == mmp_pkg::MODE_SPEC_TEST) ? mmp_pkg::RST_SYS_TEST : mmp_pkg::RST_SYS_CTL;
    end
    else if (wr_sys)
    begin
      sys_ctl_r  <= (sys_ctl_r & ~sys_mask) | (WDATA & sys_mask);
      sys_used_r <= 1'b1;
    end
  end

  // page index, upper two bits always zero
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      page_idx_r <= mmp_pkg::RST_PAGE_IDX;
    else if (wr_page)
      page_idx_r <= WDATA & mmp_pkg::MASK_PAGE_IDX;
  end

  // size register reflects the integration switches
  assign size_first = {REG_SIZE_2K, 1'b0, EE_SIZE_SEL, 1'b0, RAM_SIZE_SEL};

  // read mux; unmapped offsets read zero
  always_comb
  begin
    unique case (ADDR)
      mmp_pkg::OFF_RAM_POS:   rdata_nxt = ram_pos;
      mmp_pkg::OFF_REG_POS:   rdata_nxt = reg_pos;
      mmp_pkg::OFF_EE_POS:    rdata_nxt = ee_pos;
      mmp_pkg::OFF_SYS_CTL:   rdata_nxt = sys_ctl_r;
      mmp_pkg::OFF_MEM_SIZE0: rdata_nxt = size_first;
      mmp_pkg::OFF_MEM_SIZE1: rdata_nxt = SIZE_SECOND;
      mmp_pkg::OFF_PAGE_IDX:  rdata_nxt = page_idx_r;
      default:                rdata_nxt = 8'h00;
    endcase
  end

  // read data valid in the cycle after the strobe, zero otherwise
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_r <= 8'h00;
    else
      rdata_r <= RD ? rdata_nxt : 8'h00;
  end
  assign RDATA = rdata_r;

  // ram region size in bytes, log2 of the mappable region
  function automatic logic [4:0] ram_region_log2(input logic [2:0] sel);
    logic [4:0] r;
    r = 5'd14;
    unique case (sel)
      3'h0:    r = 5'd11;
      3'h1:    r = 5'd12;
      3'h2:    r = 5'd13;
      3'h3:    r = 5'd13;
      default: r = 5'd14;
    endcase
    return r;
  endfunction : ram_region_log2

  // allocated ram size in bytes, in steps of 2K
  function automatic logic [15:0] ram_alloc(input logic [2:0] sel);
    return {10'h000, ({3'h0, sel} + 6'h01)} << 11;
  endfunction : ram_alloc

  logic [4:0]  ram_lg;
  logic [15:0] ram_region_mask;
  logic [15:0] ram_size;
  logic [15:0] ram_base_nxt;
  logic [15:0] reg_base_nxt;
  logic [15:0] ee_base_nxt;
  logic [15:0] reg_end;
  logic [15:0] ee_size;
  logic [15:0] reg_size;
  logic        hit_reg;
  logic        hit_ram;
  logic        hit_ee;
  logic        hit_flash;
  logic [4:0]  sel_nxt;
  logic [15:0] ram_base_r;
  logic [15:0] reg_base_r;
  logic [15:0] ee_base_r;
  logic [4:0]  sel_r;
  logic [1:0]  stretch_r;

  assign ram_lg          = ram_region_log2(RAM_SIZE_SEL);
  assign ram_region_mask = 16'hffff << ram_lg;
  assign ram_size        = ram_alloc(RAM_SIZE_SEL);
  // high-align places ram at the top of its mappable region
  assign ram_base_nxt = ({ram_pos[7:3], 11'h000} & ram_region_mask) |
                        (ram_pos[mmp_pkg::RAM_ALIGN_BIT] ?
                         ((~ram_region_mask) - ram_size + 16'h0001) : 16'h0000);
  assign reg_base_nxt = {1'b0, reg_pos[6:3], 11'h000};
  assign ee_base_nxt  = {ee_pos[7:3], 11'h000};
  assign reg_size     = REG_SIZE_2K ? 16'h0800 : 16'h0400;
  // strap codes 1..3 give 2K, 4K, 8K; code 0 is gated in the hit logic
  assign ee_size      = 16'h0400 << EE_SIZE_SEL;
  assign reg_end      = reg_base_r + reg_size;

  // decode uses registered bases: a write shows one cycle later
  assign hit_reg   = (MAP_ADDR >= reg_base_r) && (MAP_ADDR < reg_end);
  assign hit_ram   = (MAP_ADDR >= ram_base_r) && ({1'b0, MAP_ADDR} < ({1'b0, ram_base_r} + {1'b0, ram_size}));
  assign hit_ee    = ee_pos[mmp_pkg::EE_EN_BIT] && (EE_SIZE_SEL != 2'h0) &&
                     (MAP_ADDR >= ee_base_r) && ({1'b0, MAP_ADDR} < ({1'b0, ee_base_r} + {1'b0, ee_size}));
  assign hit_flash = sys_ctl_r[mmp_pkg::FLASH_EN_BIT] &&
                     (MAP_ADDR[15] || !sys_ctl_r[mmp_pkg::FLASH_HALF_BIT]);
  // one-hot select, fixed priority
  assign sel_nxt = hit_reg   ? 5'h01 :
                   hit_ram   ? 5'h02 :
                   hit_ee    ? 5'h04 :
                   hit_flash ? 5'h08 : 5'h10;

  // map registers, one cycle behind the position registers
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ram_base_r <= 16'h0000;
      reg_base_r <= 16'h0000;
      ee_base_r  <= 16'h0000;
      sel_r      <= 5'h10;
      stretch_r  <= 2'h0;
    end
    else
    begin
      ram_base_r <= ram_base_nxt;
      reg_base_r <= reg_base_nxt;
      ee_base_r  <= ee_base_nxt;
      sel_r      <= sel_nxt;
      stretch_r  <= single_or_periph ? 2'h0 : sys_ctl_r[mmp_pkg::STRETCH_LSB +: 2];
    end
  end

  assign MAP_SEL       = sel_r;
  assign STRETCH_COUNT = stretch_r;
  assign RAM_BASE      = ram_base_r;
  assign REG_BASE      = reg_base_r;
  assign EE_BASE       = ee_base_r;

  // page reads remembered for the upper-bit check on the returned byte
  logic rd_page_q;
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rd_page_q <= 1'b0;
    else
      rd_page_q <= RD && (ADDR == mmp_pkg::OFF_PAGE_IDX);
  end

  // assertions
  a_ram_once_lock: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_ram && ram_used && !special |=> $stable(ram_pos))
    else $error("ram position changed after first write");
  a_reg_once_lock: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_reg && reg_used && !special |=> $stable(reg_pos))
    else $error("register position changed after first write");
  a_ee_enable_any: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_ee |=> ee_pos[0] == $past(WDATA[0]))
    else $error("eeprom enable write lost");
  a_page_upper_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    rd_page_q |-> RDATA[7:6] == 2'h0)
    else $error("page index upper bits not zero");
  a_map_delay: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_reg && special |=> ##1 reg_base_r == {1'b0, $past(WDATA[6:3], 2), 11'h000})
    else $error("register base not updated");
  a_reg_base_low: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    REG_BASE[15] == 1'b0)
    else $error("register base above low half");
  a_ee_off_nohit: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !ee_pos[0] |=> !sel_r[2])
    else $error("eeprom selected while disabled");
  a_size_readonly: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    RD && ADDR == mmp_pkg::OFF_MEM_SIZE1 |=> RDATA == SIZE_SECOND)
    else $error("size register read wrong");
  a_stretch_single: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    single_or_periph |=> STRETCH_COUNT == 2'h0)
    else $error("stretch active in single chip");

  c_ram_write: cover property (@(posedge CORE_CLK) disable iff (!RST_N) wr_ram && !ram_used);
  c_ee_hit:    cover property (@(posedge CORE_CLK) disable iff (!RST_N) sel_r[2]);
  c_reg_hit:   cover property (@(posedge CORE_CLK) disable iff (!RST_N) sel_r[0]);

endmodule : mmp_top
`default_nettype wire

// ### mmp_top_tb.sv
/*
  mmp_top_tb: self-checking bench for mmp_top with a core bus model.
  Assumes: straps fixed per run, mode changed only under reset.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module mmp_top_tb;
  localparam logic [7:0] SIZE2 = 8'h41;
  logic        CORE_CLK = 1'b0;
  logic        RST_N    = 1'b0;
  logic [2:0]  MODE     = mmp_pkg::MODE_NORM_SINGLE;
  logic [15:0] MAP_ADDR = 16'h0000;
  logic [7:0]  ADDR, WDATA, RDATA, d;
  logic        WR, RD;
  logic [4:0]  MAP_SEL;
  logic [1:0]  STRETCH_COUNT;
  logic [15:0] RAM_BASE, REG_BASE, EE_BASE;
  int          n_errors   = 0;
  int          n_compared = 0;

  always #4 CORE_CLK = ~CORE_CLK;

  // 2K registers, 4K eeprom, 6K ram in an 8K region
  mmp_top #(.EE_BASE_ONCE(1'b0), .SIZE_SECOND(SIZE2)) dut (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .MODE(MODE), .REG_SIZE_2K(1'b1),
    .EE_SIZE_SEL(2'h2), .RAM_SIZE_SEL(3'h2), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .MAP_ADDR(MAP_ADDR), .MAP_SEL(MAP_SEL),
    .STRETCH_COUNT(STRETCH_COUNT), .RAM_BASE(RAM_BASE), .REG_BASE(REG_BASE),
    .EE_BASE(EE_BASE));

  mmp_core_model core (
    .clk(CORE_CLK), .rdata(RDATA), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD));

  // mode may only move while reset is held
  task automatic rst(input logic [2:0] m);
    @(posedge CORE_CLK);
    RST_N <= 1'b0;
    MODE  <= m;
    repeat (20) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
  endtask : rst

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    core.rd_reg(a, d);
    `CHK(d, e)
  endtask : rchk

  // bases follow a write one cycle late
  task automatic settle;
    repeat (2) @(posedge CORE_CLK);
    #1;
  endtask : settle

  task automatic sel(input logic [15:0] a);
    @(posedge CORE_CLK);
    MAP_ADDR <= a;
    @(posedge CORE_CLK);
    #1;
  endtask : sel

  task automatic t_reset_vals;
    rchk(8'h10, 8'h09);
    rchk(8'h11, 8'h00);
    rchk(8'h12, 8'h01);
    rchk(8'h30, 8'h00);
    rchk(8'h20, 8'h00);
    rchk(8'h1c, 8'ha2);
    rchk(8'h1d, SIZE2);
    `CHK(RAM_BASE, 16'h0800)
    `CHK(STRETCH_COUNT, 2'h0)
    $display("test reset_vals done");
  endtask : t_reset_vals

  task automatic t_page;
    core.wr_reg(8'h30, 8'hff);
    rchk(8'h30, 8'h3f);
    core.wr_reg(8'h1c, 8'h00);
    core.wr_reg(8'h1d, 8'hff);
    rchk(8'h1c, 8'ha2);
    rchk(8'h1d, SIZE2);
    $display("test page done");
  endtask : t_page

  task automatic t_once;
    core.wr_reg(8'h11, 8'hff);
    #1 `CHK(REG_BASE, 16'h0000)
    @(posedge CORE_CLK);
    #1 `CHK(REG_BASE, 16'h7800)
    rchk(8'h11, 8'h78);
    core.wr_reg(8'h11, 8'h08);
    rchk(8'h11, 8'h78);
    core.wr_reg(8'h10, 8'h40);
    core.wr_reg(8'h10, 8'h81);
    rchk(8'h10, 8'h40);
    settle();
    `CHK(RAM_BASE, 16'h4000)
    $display("test once done");
  endtask : t_once

  task automatic t_eeprom;
    core.wr_reg(8'h12, 8'ha8);
    rchk(8'h12, 8'ha8);
    sel(16'ha900);
    `CHK(MAP_SEL[2], 1'b0)
    core.wr_reg(8'h12, 8'ha9);
    settle();
    `CHK(EE_BASE, 16'ha800)
    sel(16'ha900);
    `CHK(MAP_SEL, 5'h04)
    core.wr_reg(8'h12, 8'hb1);
    settle();
    `CHK(EE_BASE, 16'hb000)
    $display("test eeprom done");
  endtask : t_eeprom

  task automatic t_special;
    rst(mmp_pkg::MODE_SPEC_SINGLE);
    core.wr_reg(8'h10, 8'h40);
    core.wr_reg(8'h10, 8'h41);
    rchk(8'h10, 8'h41);
    settle();
    `CHK(RAM_BASE, 16'h4800)
    sel(16'h4900);
    `CHK(MAP_SEL, 5'h02)
    core.wr_reg(8'h11, 8'h48);
    sel(16'h4900);
    `CHK(MAP_SEL, 5'h01)
    core.wr_reg(8'h11, 8'h50);
    settle();
    `CHK(REG_BASE, 16'h5000)
    $display("test special done");
  endtask : t_special

  task automatic t_stretch;
    rst(mmp_pkg::MODE_NORM_WIDE);
    rchk(8'h13, 8'h0d);
    `CHK(STRETCH_COUNT, 2'h3)
    core.wr_reg(8'h13, 8'h05);
    settle();
    `CHK(STRETCH_COUNT, 2'h1)
    rchk(8'h13, 8'h05);
    $display("test stretch done");
  endtask : t_stretch

  // test mode resets with flash out of the map; then upper half only
  task automatic t_flash;
    rst(mmp_pkg::MODE_SPEC_TEST);
    rchk(8'h13, 8'h0c);
    `CHK(STRETCH_COUNT, 2'h3)
    sel(16'h9000);
    `CHK(MAP_SEL, 5'h10)
    core.wr_reg(8'h13, 8'h03);
    settle();
    `CHK(STRETCH_COUNT, 2'h0)
    sel(16'h9000);
    `CHK(MAP_SEL, 5'h08)
    sel(16'h4000);
    `CHK(MAP_SEL, 5'h10)
    $display("test flash done");
  endtask : t_flash

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // main sequence
  initial
  begin
    rst(mmp_pkg::MODE_NORM_SINGLE);
    t_reset_vals();
    t_page();
    t_once();
    t_eeprom();
    t_special();
    t_stretch();
    t_flash();
    stop_test();
  end

  // the run needs well under 1000 cycles
  initial
  begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule : mmp_top_tb
`default_nettype wire

// ### mmp_wreg.sv
/*
  mmp_wreg: one 8-bit position register with write-once protection.
  Assumes: the write strobe is one cycle and the protect mask is stable
  while it is high.
*/
`timescale 1ns/1ps
`default_nettype none
module mmp_wreg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] wmask_any,
  input  wire logic [7:0] wmask_once,
  input  wire logic       once_ok,
  output logic      [7:0] q,
  output logic            used
);

  logic [7:0] mask;

  // once-only bits open only until the first write since reset
  assign mask = wmask_any | (once_ok && !used ? wmask_once : 8'h00);

  // used is set by any write, so a later write cannot reopen the register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q    <= RESET_VAL;
      used <= 1'b0;
    end
    else if (wr)
    begin
      q    <= (q & ~mask) | (wdata & mask);
      used <= 1'b1;
    end
  end

endmodule : mmp_wreg
`default_nettype wire
